// File: sps_consts.svh
// Offsets, field positions, reset values and timing counts of the socket status bank.
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH
`define SPS_AW             8
`define SPS_OFF_EVENT      8'h00
`define SPS_OFF_MASK       8'h04
`define SPS_OFF_STATUS     8'h08
`define SPS_OFF_FORCE      8'h0c
`define SPS_B_FUT_A_CAP    31
`define SPS_B_FUT_B_CAP    30
`define SPS_B_LOW_CAP      29
`define SPS_B_HIGH_CAP     28
`define SPS_B_RETEST       14
`define SPS_B_VOLT_HI      13
`define SPS_B_VOLT_LO      10
`define SPS_B_BAD_SUPPLY   9
`define SPS_B_DATA_LOSS    8
`define SPS_B_UNRECOG      7
`define SPS_B_IRQ_PIN      6
`define SPS_B_CARDBUS      5
`define SPS_B_LEGACY       4
`define SPS_B_POWERED      3
`define SPS_B_CD_B         2
`define SPS_B_CD_A         1
`define SPS_B_STS_PIN      0
`define SPS_EV_W           4
`define SPS_CAP_RESET      2'h3
`define SPS_CLK_NS         4
`define SPS_INTERROG_NS    400
`define SPS_INTERROG_CYC   ((`SPS_INTERROG_NS + `SPS_CLK_NS - 1) / `SPS_CLK_NS)
`endif

// File: sps_pkg.sv
// Types shared by the socket status bank modules.
`default_nettype none
package sps_pkg;
    typedef logic [31:0] sps_word_t;
    typedef enum logic [0:0] {
        SPS_IDLE,
        SPS_RUN
    } sps_seq_e;
endpackage
`default_nettype wire

// File: sps_interrog_if.sv
// Handshake between the status bank and the card interrogation sequencer.
`timescale 1ns/10ps
`default_nettype none
interface sps_interrog_if;
    logic start;
    logic busy;
    logic done;
    modport ctrl (output start, input busy, input done);
    modport seq  (input start, output busy, output done);
endinterface
`default_nettype wire

// File: sps_edge.sv
// Per-bit rise and fall detector for the socket level bits.
`timescale 1ns/10ps
`default_nettype none
module sps_edge #(
    parameter int           N    = 4,
    parameter logic [N-1:0] INIT = '0
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [N-1:0] level_i,
    output logic      [N-1:0] rise_o,
    output logic      [N-1:0] fall_o
);
    logic [N-1:0] prev;

    // One history flop and two edge terms for each watched bit.
    // History starts at the reset level of its bit, so release gives no false edge.
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_bit
            always_ff @(posedge sys_clk_i) begin
                if (!rst_n_i) begin
                    prev[g] <= INIT[g];
                end else begin
                    prev[g] <= level_i[g];
                end
            end
            assign rise_o[g] = level_i[g] & ~prev[g];
            assign fall_o[g] = ~level_i[g] & prev[g];
        end
    endgenerate
endmodule
`default_nettype wire

// File: sps_interrog.sv
// Card interrogation sequencer: drives the detect pins for a fixed time.
`timescale 1ns/10ps
`default_nettype none
`include "sps_consts.svh"
module sps_interrog #(
    parameter int DUR = `SPS_INTERROG_CYC
) (
    input  wire logic   sys_clk_i,
    input  wire logic   rst_n_i,
    sps_interrog_if.seq ifc,
    output logic        cd_oe_o
);
    localparam int CW = $clog2(DUR + 1);
    sps_pkg::sps_seq_e state;
    logic [CW-1:0]     cnt;

    // Start runs the count down; done pulses on the last cycle of the drive.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state <= sps_pkg::SPS_IDLE;
            cnt   <= '0;
        end else begin
            case (state)
                sps_pkg::SPS_IDLE: begin
                    if (ifc.start) begin
                        state <= sps_pkg::SPS_RUN;
                        cnt   <= CW'(DUR - 1);
                    end
                end
                sps_pkg::SPS_RUN: begin
                    if (cnt == '0) begin
                        state <= sps_pkg::SPS_IDLE;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                default: state <= sps_pkg::SPS_IDLE;
            endcase
        end
    end

    // The detect pins are pulled low by the device while it probes the card.
    assign ifc.busy = (state == sps_pkg::SPS_RUN);
    assign ifc.done = ifc.busy && (cnt == '0);
    assign cd_oe_o  = ifc.busy;
endmodule
`default_nettype wire

// File: sps_status_bank.sv
// Socket presence status bank with event, mask and force registers.
// Overview of operation
// R1: Future supply capability bits 31 and 30 always read zero.
// R2: Low and high supply capability bits read one unless forced off.
// R3: Bits 27 down to 14 of the status word read zero.
// R4: Card voltage bits and card type change only at card interrogation; here force writes also set them.
// R5: Bad supply request bit sets on an invalid power request, resets zero.
// R6: Data loss bit sets when a removal may have lost data.
// R7: Unrecognized card bit sets on bad card, holds until a valid one.
// R8: Interrupt pin level bit mirrors the live card ready pin.
// R9: CardBus and legacy type bits hold until the next interrogation.
// R10: Powered bit shows socket power state, zero at reset.
// R11: Each card detect bit mirrors its pin, one meaning no card.
// R12: Card detect bits freeze while the device drives those pins.
// R13: Status pin bit mirrors the live card status change pin.
// R14: Force register writes set status bits 13 to 7, 5 and 4 at once; bits 29 and 28 clear, and bits 3 to 0 set event flags.
// R15: Status pin event: rising edge for CardBus, both edges for legacy.
// R16: Power and detect bit changes raise events, cleared by writing one.
// R17: Force retest bit re-runs interrogation and refreshes card bits.
// R18: Writes to the status word address change nothing.
`timescale 1ns/10ps
`default_nettype none
`include "sps_consts.svh"
module sps_status_bank #(
    parameter int DUR = `SPS_INTERROG_CYC
) (
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic [`SPS_AW-1:0]   addr_i,
    input  wire logic [31:0]          wdata_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output logic      [31:0]          rdata_o,
    output logic                      irq_o,
    input  wire logic                 card_detect_a_pin_i,
    input  wire logic                 card_detect_b_pin_i,
    output logic                      card_detect_a_pin_o,
    output logic                      card_detect_b_pin_o,
    output logic                      card_detect_oe_o,
    input  wire logic                 card_status_pin_i,
    input  wire logic                 card_irq_pin_i,
    input  wire logic                 socket_powered_i,
    input  wire logic                 bad_supply_req_i,
    input  wire logic                 removal_loss_i,
    input  wire logic [3:0]           card_sense_volt_i,
    input  wire logic                 card_sense_valid_i,
    input  wire logic                 card_sense_cardbus_i
);
    localparam int INTERROG_CYC = DUR;

    sps_interrog_if    iq ();
    sps_pkg::sps_word_t status_word;
    logic [1:0]        supply_cap;
    logic [3:0]        card_volt;
    logic              bad_supply_request;
    logic              removal_data_loss;
    logic              unrecognized_card;
    logic              card_irq_pin_level;
    logic              cardbus_type_detected;
    logic              legacy_card_detected;
    logic              socket_powered;
    logic              card_detect_a_level;
    logic              card_detect_b_level;
    logic              card_status_pin_level;
    logic [`SPS_EV_W-1:0] event_flags;
    logic [`SPS_EV_W-1:0] event_mask;
    logic [`SPS_EV_W-1:0] ev_rise;
    logic [`SPS_EV_W-1:0] ev_fall;
    logic [`SPS_EV_W-1:0] ev_set;
    logic [`SPS_EV_W-1:0] ev_clr;
    logic              wr_event;
    logic              wr_mask;
    logic              wr_force;
    logic              card_present;
    logic              card_present_d;

    // Register decode; the status address has no write decode at all.
    assign wr_event = wr_i && (addr_i == `SPS_OFF_EVENT);
    assign wr_mask  = wr_i && (addr_i == `SPS_OFF_MASK);
    assign wr_force = wr_i && (addr_i == `SPS_OFF_FORCE); // R18

    // Interrogation sequencer; it owns the detect pin drivers while busy.
    sps_interrog #(
        .DUR (DUR)
    ) u_interrog (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .ifc       (iq.seq),
        .cd_oe_o   (card_detect_oe_o)
    );
    assign card_detect_a_pin_o = 1'b0;
    assign card_detect_b_pin_o = 1'b0;

    // Live pin levels; detect bits hold their value while the pins are driven.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            card_irq_pin_level    <= 1'b0;
            card_status_pin_level <= 1'b0;
            socket_powered        <= 1'b0;
            card_detect_a_level   <= 1'b1;
            card_detect_b_level   <= 1'b1;
        end else begin
            card_irq_pin_level    <= card_irq_pin_i; // R8
            card_status_pin_level <= card_status_pin_i; // R13
            socket_powered        <= socket_powered_i; // R10
            if (!iq.busy) begin
                card_detect_a_level <= card_detect_a_pin_i; // R11
                card_detect_b_level <= card_detect_b_pin_i; // R11
            end // R12
        end
    end

    // Insertion is both detect bits low; it or a retest starts interrogation.
    assign card_present = ~card_detect_a_level & ~card_detect_b_level;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            card_present_d <= 1'b0;
        end else begin
            card_present_d <= card_present;
        end
    end
    assign iq.start = !iq.busy && ((card_present && !card_present_d) ||
                      (wr_force && wdata_i[`SPS_B_RETEST])); // R17

    // Capability bits: a force write with bit 29 or 28 set clears that bit.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            supply_cap <= `SPS_CAP_RESET;
        end else if (wr_force) begin
            supply_cap <= supply_cap &
                          ~wdata_i[`SPS_B_LOW_CAP:`SPS_B_HIGH_CAP]; // R2
        end
    end

    // Card facts load at the end of interrogation; force writes set bits.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            card_volt             <= 4'h0;
            unrecognized_card     <= 1'b0;
            cardbus_type_detected <= 1'b0;
            legacy_card_detected  <= 1'b0;
        end else begin
            if (iq.done && card_sense_valid_i) begin
                card_volt             <= card_sense_volt_i; // R4
                unrecognized_card     <= 1'b0; // R7
                cardbus_type_detected <= card_sense_cardbus_i; // R9
                legacy_card_detected  <= ~card_sense_cardbus_i; // R9
            end else if (iq.done) begin
                unrecognized_card     <= 1'b1; // R7
            end
            if (wr_force) begin
                card_volt <= card_volt | wdata_i[`SPS_B_VOLT_HI:`SPS_B_VOLT_LO]; // R14
                if (wdata_i[`SPS_B_UNRECOG]) begin
                    unrecognized_card <= 1'b1; // R14
                end
                if (wdata_i[`SPS_B_CARDBUS]) begin
                    cardbus_type_detected <= 1'b1; // R14
                end
                if (wdata_i[`SPS_B_LEGACY]) begin
                    legacy_card_detected <= 1'b1; // R14
                end
            end
        end
    end

    // Error bits are sticky until the next card interrogation completes.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            bad_supply_request <= 1'b0;
            removal_data_loss  <= 1'b0;
        end else begin
            if (bad_supply_req_i || (wr_force && wdata_i[`SPS_B_BAD_SUPPLY])) begin
                bad_supply_request <= 1'b1; // R5
            end else if (iq.done) begin
                bad_supply_request <= 1'b0;
            end
            if (removal_loss_i || (wr_force && wdata_i[`SPS_B_DATA_LOSS])) begin
                removal_data_loss <= 1'b1; // R6
            end else if (iq.done) begin
                removal_data_loss <= 1'b0;
            end
        end
    end

    // Edges of power, detect b, detect a and status pin bits.
    sps_edge #(
        .N    (`SPS_EV_W),
        .INIT (4'h6)
    ) u_edge (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .level_i   ({socket_powered, card_detect_b_level,
                     card_detect_a_level, card_status_pin_level}),
        .rise_o    (ev_rise),
        .fall_o    (ev_fall)
    );
    assign ev_set[3:1] = ev_rise[3:1] | ev_fall[3:1]; // R16
    assign ev_set[0]   = ev_rise[0] | (ev_fall[0] & legacy_card_detected); // R15
    assign ev_clr      = wr_event ? wdata_i[`SPS_EV_W-1:0] : '0;

    // Sticky event flags; a set in the clearing cycle wins over the clear.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            event_flags <= '0;
        end else begin
            event_flags <= (event_flags & ~ev_clr) | ev_set |
                           (wr_force ? wdata_i[`SPS_EV_W-1:0] : '0); // R16
        end
    end

    // Mask register gates events onto the single level interrupt.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            event_mask <= '0;
        end else if (wr_mask) begin
            event_mask <= wdata_i[`SPS_EV_W-1:0];
        end
    end
    assign irq_o = |(event_flags & event_mask);

    // Status word assembly; unlisted bits stay zero.
    always_comb begin
        status_word = '0; // R3
        status_word[`SPS_B_FUT_A_CAP] = 1'b0; // R1
        status_word[`SPS_B_FUT_B_CAP] = 1'b0; // R1
        status_word[`SPS_B_LOW_CAP:`SPS_B_HIGH_CAP] = supply_cap; // R2
        status_word[`SPS_B_VOLT_HI:`SPS_B_VOLT_LO] = card_volt;
        status_word[`SPS_B_BAD_SUPPLY] = bad_supply_request;
        status_word[`SPS_B_DATA_LOSS]  = removal_data_loss;
        status_word[`SPS_B_UNRECOG]    = unrecognized_card;
        status_word[`SPS_B_IRQ_PIN]    = card_irq_pin_level;
        status_word[`SPS_B_CARDBUS]    = cardbus_type_detected;
        status_word[`SPS_B_LEGACY]     = legacy_card_detected;
        status_word[`SPS_B_POWERED]    = socket_powered;
        status_word[`SPS_B_CD_B]       = card_detect_b_level;
        status_word[`SPS_B_CD_A]       = card_detect_a_level;
        status_word[`SPS_B_STS_PIN]    = card_status_pin_level;
    end

    // Read data stands only in the cycle after the strobe; else zero.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            case (addr_i)
                `SPS_OFF_EVENT:  rdata_o <= {28'h0, event_flags};
                `SPS_OFF_MASK:   rdata_o <= {28'h0, event_mask};
                `SPS_OFF_STATUS: rdata_o <= status_word;
                default:         rdata_o <= '0;
            endcase
        end else begin
            rdata_o <= '0;
        end
    end

    a_future_cap_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R1
        rd_i && addr_i == `SPS_OFF_STATUS |=> rdata_o[31:30] == 2'h0)
        else $error("future capability bits not zero");

    a_cap_no_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R2
        !(wr_force && |wdata_i[29:28]) |=> supply_cap == $past(supply_cap))
        else $error("capability changed without a force");

    a_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R3
        rd_i |=> rdata_o[27:14] == 14'h0)
        else $error("reserved bits not zero");

    a_volt_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R4
        !iq.done && !wr_force |=> $stable(card_volt))
        else $error("card voltage bits moved outside interrogation");

    a_bad_supply_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R5
        bad_supply_req_i |=> bad_supply_request ##1 rd_i && addr_i == `SPS_OFF_STATUS
        |=> rdata_o[9])
        else $error("bad supply request not reported");

    a_unrecog_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R7
        iq.done && !card_sense_valid_i |=> unrecognized_card)
        else $error("unrecognized card not flagged");

    a_irq_pin_read: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R8
        rd_i && addr_i == `SPS_OFF_STATUS |=> rdata_o[6] == $past(card_irq_pin_i, 2))
        else $error("interrupt pin level wrong");

    a_cd_frozen: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R12
        iq.busy && $past(iq.busy) |-> $stable(card_detect_a_level) &&
        $stable(card_detect_b_level))
        else $error("detect bits moved during interrogation");

    a_legacy_fall_ev: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R15
        legacy_card_detected && $fell(card_status_pin_level) |=> event_flags[0])
        else $error("legacy status fall missed");

    a_power_event: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R16
        $changed(socket_powered) |=> event_flags[3])
        else $error("power change event missed");

    a_retest_runs: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R17
        wr_force && wdata_i[14] && !iq.busy |=> iq.busy ##[1:INTERROG_CYC] iq.done)
        else $error("retest did not run interrogation");
endmodule
`default_nettype wire

// File: sps_card_model.sv
// Behavioural card in the socket: detect, status, ready and sense lines.
`timescale 1ns/10ps
`default_nettype none
module sps_card_model (
    input  wire logic       cd_a_drv_i,
    input  wire logic       cd_b_drv_i,
    input  wire logic       cd_oe_i,
    output logic            cd_a_o,
    output logic            cd_b_o,
    output logic            status_pin_o,
    output logic            irq_pin_o,
    output logic [3:0]      sense_volt_o,
    output logic            sense_valid_o,
    output logic            sense_cardbus_o
);
    logic       present = 1'b0;
    logic [3:0] volt    = 4'h0;
    logic       ok      = 1'b0;
    logic       cb      = 1'b0;
    logic       sts     = 1'b0;
    logic       rdy     = 1'b0;

    // Detect lines have pull-ups; a card or the driving device pulls them low.
    assign cd_a_o = (cd_oe_i && !cd_a_drv_i) ? 1'b0 : !present;
    assign cd_b_o = (cd_oe_i && !cd_b_drv_i) ? 1'b0 : !present;
    assign status_pin_o = sts;
    assign irq_pin_o    = rdy;
    // Without a card the sense lines carry no data: volt and type show the inverse of the last value, valid reads low.
    assign sense_volt_o    = present ? volt : ~volt;
    assign sense_cardbus_o = present ? cb : ~cb;
    assign sense_valid_o   = present && ok;

    // Called just after a rising edge to insert, swap or remove a card.
    task automatic set_card(input logic p, input logic [3:0] v, input logic k, input logic c);
        present <= p;
        volt    <= v;
        ok      <= k;
        cb      <= c;
    endtask

    // Called just after a rising edge to move the status and ready pins.
    task automatic set_pins(input logic s, input logic r);
        sts <= s;
        rdy <= r;
    endtask
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the socket status bank against an integer model.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int DUR_SIM = 8;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, pwr = 1'b0, bad = 1'b0, loss = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic irq, cda_o, cdb_o, oe, cd_a, cd_b, sts_pin, irq_pin, svalid, scb;
    logic [3:0] svolt;
    int fails = 0, compares = 0, seed = 32'h24d2, n, r;
    int e_cap = 3, e_volt = 0, e_bad = 0, e_loss = 0, e_unrec = 0, e_irqp = 0, e_cb = 0;
    int e_leg = 0, e_pwr = 0, e_cdb = 1, e_cda = 1, e_sts = 0, e_ev = 0;

    sps_status_bank #(.DUR(DUR_SIM)) u_sps_status_bank (.sys_clk_i(clk), .rst_n_i(rst_n),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq),
        .card_detect_a_pin_i(cd_a), .card_detect_b_pin_i(cd_b), .card_detect_a_pin_o(cda_o),
        .card_detect_b_pin_o(cdb_o), .card_detect_oe_o(oe), .card_status_pin_i(sts_pin),
        .card_irq_pin_i(irq_pin), .socket_powered_i(pwr), .bad_supply_req_i(bad),
        .removal_loss_i(loss), .card_sense_volt_i(svolt), .card_sense_valid_i(svalid),
        .card_sense_cardbus_i(scb));
    sps_card_model u_card (.cd_a_drv_i(cda_o), .cd_b_drv_i(cdb_o), .cd_oe_i(oe), .cd_a_o(cd_a),
        .cd_b_o(cd_b), .status_pin_o(sts_pin), .irq_pin_o(irq_pin), .sense_volt_o(svolt),
        .sense_valid_o(svalid), .sense_cardbus_o(scb));

    // Clock of 4 ns period.
    always #2 clk = ~clk;

    // Expected status word packed from the model fields.
    function automatic logic [31:0] exp_st();
        exp_st = (e_cap << 28) | (e_volt << 10) | (e_bad << 9) | (e_loss << 8) | (e_unrec << 7)
            | (e_irqp << 6) | (e_cb << 5) | (e_leg << 4) | (e_pwr << 3) | (e_cdb << 2)
            | (e_cda << 1) | e_sts;
    endfunction

    // Compare tasks count every check and report a mismatch at once.
    task automatic chk_word(input string name, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic chk_bit(input string name, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %b seen %b", name, e, g);
        end
    endtask

    // One-cycle register write and read; read data stands in the cycle after the strobe.
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk_word(name, e, rdata);
    endtask
    task automatic st_chk();
        rd_chk("status", 8'h08, exp_st());
        rd_chk("event", 8'h00, e_ev);
    endtask

    // Pin bits pass one flop, so wait before reading them.
    task automatic settle();
        repeat (3) @(posedge clk);
    endtask

    // Waits for the detect-pin drive window and counts its cycles.
    task automatic run_interrog(output int cnt);
        int i;
        i = 0;
        cnt = 0;
        #1;
        while (oe !== 1'b1 && i < 50) begin
            @(posedge clk);
            #1;
            i++;
        end
        while (oe === 1'b1 && cnt < 100) begin
            @(posedge clk);
            #1;
            cnt++;
        end
        repeat (2) @(posedge clk);
    endtask

    // Model of the card bits at the end of interrogation.
    task automatic fin(input int ok, input int v, input int c);
        if (ok) begin
            e_volt = v;
            e_cb = c;
            e_leg = !c;
            e_unrec = 0;
        end else begin
            e_unrec = 1;
        end
        e_bad = 0;
        e_loss = 0;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog cuts a hang short.
    initial begin
        #40000;
        fails++;
        print_verdict();
    end

    // Main sequence.
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        settle();
        st_chk();
        rd_chk("mask", 8'h04, 32'h0);
        rd_chk("force", 8'h0c, 32'h0);
        rd_chk("unmapped", 8'h10, 32'h0);
        chk_bit("irq", 1'b0, irq);
        bus_wr(8'h08, 32'hffffffff);
        bus_wr(8'h20, 32'hffffffff);
        st_chk();
        bus_wr(8'h04, 32'hffffffff);
        rd_chk("mask", 8'h04, 32'hf);
        bus_wr(8'h04, 32'h8);
        @(posedge clk);
        pwr <= 1'b1;
        e_pwr = 1;
        e_ev = 8;
        settle();
        st_chk();
        chk_bit("irq", 1'b1, irq);
        bus_wr(8'h04, 32'h0);
        @(posedge clk);
        chk_bit("irq", 1'b0, irq);
        bus_wr(8'h00, 32'h8);
        e_ev = 0;
        @(posedge clk);
        u_card.set_card(1'b1, 4'h3, 1'b1, 1'b1);
        run_interrog(n);
        chk_word("oe_cycles", DUR_SIM, n);
        e_cda = 0;
        e_cdb = 0;
        e_ev = 6;
        fin(1, 3, 1);
        st_chk();
        bus_wr(8'h00, 32'hf);
        e_ev = 0;
        @(posedge clk);
        u_card.set_pins(1'b1, 1'b1);
        e_sts = 1;
        e_irqp = 1;
        e_ev = 1;
        settle();
        st_chk();
        bus_wr(8'h00, 32'hf);
        e_ev = 0;
        u_card.set_pins(1'b0, 1'b0);
        e_sts = 0;
        e_irqp = 0;
        settle();
        st_chk();
        @(posedge clk);
        bad <= 1'b1;
        loss <= 1'b1;
        @(posedge clk);
        bad <= 1'b0;
        loss <= 1'b0;
        e_bad = 1;
        e_loss = 1;
        st_chk();
        @(posedge clk);
        u_card.set_card(1'b1, 4'hc, 1'b1, 1'b0);
        bus_wr(8'h0c, 32'h4000);
        run_interrog(n);
        chk_word("oe_cycles", DUR_SIM, n);
        fin(1, 12, 0);
        st_chk();
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            u_card.set_pins(k == 0, 1'b0);
            e_sts = (k == 0);
            e_ev = 1;
            settle();
            st_chk();
            bus_wr(8'h00, 32'h1);
            e_ev = 0;
        end
        @(posedge clk);
        u_card.set_card(1'b0, 4'h0, 1'b0, 1'b0);
        e_cda = 1;
        e_cdb = 1;
        e_ev = 6;
        settle();
        st_chk();
        bus_wr(8'h00, 32'hf);
        e_ev = 0;
        bus_wr(8'h0c, 32'h4000);
        rd_chk("frozen", 8'h08, exp_st());
        rd_chk("frozen", 8'h08, exp_st());
        chk_bit("oe", 1'b1, oe);
        chk_bit("cd_drive", 1'b0, cda_o | cdb_o);
        run_interrog(n);
        fin(0, 0, 0);
        st_chk();
        bus_wr(8'h0c, 32'h20000f0f);
        e_cap = 1;
        e_volt = e_volt | 3;
        e_bad = 1;
        e_loss = 1;
        e_ev = 15;
        @(posedge clk);
        st_chk();
        rd_chk("force", 8'h0c, 32'h0);
        bus_wr(8'h04, 32'h1);
        @(posedge clk);
        chk_bit("irq", 1'b1, irq);
        bus_wr(8'h00, 32'hf);
        e_ev = 0;
        @(posedge clk);
        chk_bit("irq", 1'b0, irq);
        u_card.set_card(1'b1, 4'h5, 1'b1, 1'b1);
        run_interrog(n);
        e_cda = 0;
        e_cdb = 0;
        e_ev = 6;
        fin(1, 5, 1);
        st_chk();
        bus_wr(8'h00, 32'hf);
        e_ev = 0;
        for (int k = 0; k < 8; k++) begin
            r = $random(seed);
            @(posedge clk);
            u_card.set_pins(r[0], r[1]);
            pwr <= r[2];
            if (r[0] && !e_sts) e_ev = e_ev | 1;
            if (r[2] != e_pwr) e_ev = e_ev | 8;
            e_sts = r[0];
            e_irqp = r[1];
            e_pwr = r[2];
            settle();
            st_chk();
            bus_wr(8'h00, 32'hf);
            e_ev = 0;
        end
        print_verdict();
    end
endmodule
`default_nettype wire
